//--- core/twm_master_rx.sv
// Function
// - START request with interface enabled waits for a free bus, then sends START.
// - After START the flag is set and status reads 0x08.
// - Address read bit selects receiver operation, write bit selects transmitter.
// - Writing one to the flag clears it and lets the bus action go on.
// - The interface only operates while the enable bit is one.
// - After the read address and its acknowledge, flag set with 0x38, 0x40 or 0x48.
// - Prescaler bits of status read zero so codes compare directly.
// - Each received byte is in the data register when the flag rises.
// - Flag plus stop request sends a STOP on the bus.
// - Flag plus start request sends a repeated START, status 0x10.
// - After repeated START any slave may be addressed in either direction.
// - In 0x10 a loaded read or write address is sent, choosing the mode.
// - Arbitration loss gives 0x38; clear releases bus or restarts when free.
// - In 0x40 or 0x50 clearing receives a byte, ACK per ack enable.
// - Byte received with ACK returned reports 0x50.
// - In 0x48 only repeated START, STOP or STOP then START is accepted.
// - In 0x58 byte is readable, then repeated START, STOP or both.
// - Start and stop together send STOP then START; stop bit self-clears.
// - Data write while flag is low is dropped and sets write collision.
`timescale 1ns/1ps
`default_nettype none

module twm_master_rx
  import twm_pkg::*;
#(
  parameter int unsigned HALF_CYCLES = twm_pkg::HALF_CYC,
  parameter int unsigned FREE_CYCLES = twm_pkg::FREE_CYC
) (
  // Clock and reset
  input  wire logic                      MCLK,
  input  wire logic                      RESET_N,
  // Register port
  input  wire logic [twm_pkg::REG_AW-1:0] ADDR,
  input  wire logic [7:0]                WDATA,
  input  wire logic                      WR,
  input  wire logic                      RD,
  output logic      [7:0]                RDATA,
  // Two-wire bus, open drain
  input  wire logic                      SCL_IN,
  output logic                           SCL_OUT,
  output logic                           SCL_OE,
  input  wire logic                      SDA_IN,
  output logic                           SDA_OUT,
  output logic                           SDA_OE,
  // Interrupt request
  output logic                           IRQ
);
  import twm_pkg::*;

  // --------------------------------------------------------------------
  // Parameter checks
  // --------------------------------------------------------------------
  if (HALF_CYCLES < 4 || HALF_CYCLES > 255) begin : g_bad_half
    $error("HALF_CYCLES must lie in 4..255");
  end
  if (FREE_CYCLES < 1 || FREE_CYCLES > 255) begin : g_bad_free
    $error("FREE_CYCLES must lie in 1..255");
  end

  localparam logic [7:0] HALF    = 8'(HALF_CYCLES);
  localparam logic [7:0] QUARTER = 8'(HALF_CYCLES / 2);
  localparam logic [7:0] FREE    = 8'(FREE_CYCLES);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  twm_ctrl_t   ctrl;
  logic [7:0]  status;
  logic [7:0]  data;
  twm_state_t  state;
  twm_state_t  next_state;
  logic [7:0]  tmr;
  logic [7:0]  next_tmr;
  logic [3:0]  bitc;
  logic [3:0]  next_bitc;
  logic [7:0]  sh;
  logic [7:0]  next_sh;
  logic [7:0]  pend;
  logic [7:0]  next_pend;
  logic        rd_mode;
  logic        next_rd_mode;
  logic        addr_ph;
  logic        next_addr_ph;
  logic        rs;
  logic        next_rs;
  logic        scl_drv;
  logic        next_scl_drv;
  logic        sda_drv;
  logic        next_sda_drv;
  logic        set_flag;
  logic        rx_cap;
  logic        clr_stop;
  logic [SYNC_LEN-1:0] scl_q;
  logic [SYNC_LEN-1:0] sda_q;
  logic        scl_s;
  logic        sda_s;
  logic [7:0]  free_cnt;

  // --------------------------------------------------------------------
  // Register decode
  // --------------------------------------------------------------------
  twm_ctrl_t   wr_c;
  wire         wr_ctrl  = WR && (ADDR == OFF_CTRL);
  wire         wr_data  = WR && (ADDR == OFF_DATA);
  assign wr_c = twm_ctrl_t'(WDATA);
  // Clearing the flag is the go signal for the bus engine
  wire         go       = wr_ctrl && wr_c.flag && wr_c.iface_enable;
  wire         bus_free = (free_cnt == FREE);
  wire         tx       = addr_ph || !rd_mode;
  wire         tmr_done = (tmr == 8'h00);
  wire         quarter  = (tmr == QUARTER);
  wire [7:0]   rd_stat  = {status[7:STAT_LSB], PRESCALE_ZERO};
  wire [7:0]   rd_mux   = (ADDR == OFF_CTRL) ? ctrl :
                          (ADDR == OFF_STAT) ? rd_stat :
                          (ADDR == OFF_DATA) ? data : 8'h00;

  // Transmitter status codes that continue with a plain clear by sending the data byte
  function automatic logic is_tx_stat(input logic [7:0] s);
    is_tx_stat = (s == ST_AW_ACK) || (s == ST_AW_NACK) ||
                 (s == ST_TX_ACK) || (s == ST_TX_NACK);
  endfunction : is_tx_stat

  // SDA pull-down wanted for the current bit slot
  function automatic logic drive_low(input logic [3:0] b, input logic t,
                                     input logic msb, input logic ae);
    if (b < BIT_ACK) begin
      drive_low = t && !msb;
    end else if (b == BIT_ACK) begin
      drive_low = !t && ae;
    end else begin
      drive_low = 1'b0;
    end
  endfunction : drive_low

  // --------------------------------------------------------------------
  // Input synchronisers and bus-free timer
  // --------------------------------------------------------------------
  // Three stages; the level moves only when stages two and three agree
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      scl_q <= '1;
      sda_q <= '1;
      scl_s <= 1'b1;
      sda_s <= 1'b1;
    end else begin
      scl_q <= {scl_q[SYNC_LEN-2:0], SCL_IN};
      sda_q <= {sda_q[SYNC_LEN-2:0], SDA_IN};
      if (scl_q[1] == scl_q[2]) scl_s <= scl_q[2];
      if (sda_q[1] == sda_q[2]) sda_s <= sda_q[2];
    end
  end

  // Both lines high long enough means nobody owns the bus
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      free_cnt <= 8'h00;
    end else if (!(scl_s && sda_s)) begin
      free_cnt <= 8'h00;
    end else if (!bus_free) begin
      free_cnt <= free_cnt + 8'h01;
    end
  end

  // --------------------------------------------------------------------
  // Bus engine
  // --------------------------------------------------------------------
  // One half SCL period per phase; data changes at the quarter point so
  // SDA never moves near an SCL edge and no false START/STOP appears.
  always_comb begin
    next_state   = state;
    next_tmr     = tmr_done ? 8'h00 : tmr - 8'h01;
    next_bitc    = bitc;
    next_sh      = sh;
    next_pend    = pend;
    next_rd_mode = rd_mode;
    next_addr_ph = addr_ph;
    next_rs      = rs;
    next_scl_drv = scl_drv;
    next_sda_drv = sda_drv;
    set_flag     = 1'b0;
    rx_cap       = 1'b0;
    clr_stop     = 1'b0;
    case (state)
      S_IDLE: begin
        next_scl_drv = 1'b0;
        next_sda_drv = 1'b0;
        if (go && wr_c.start_request) begin
          next_rs    = 1'b0;
          next_state = S_WAIT_FREE;
        end
      end
      S_WAIT_FREE: begin
        if (bus_free) begin
          next_sda_drv = 1'b1;
          next_tmr     = HALF;
          next_state   = S_START_HOLD;
        end
      end
      S_START_HOLD: begin
        if (tmr_done) begin
          next_pend    = rs ? ST_RSTART : ST_START;
          next_rs      = 1'b1;
          next_bitc    = BIT_END;
          next_scl_drv = 1'b1;
          next_tmr     = HALF;
          next_state   = S_SCL_LOW;
        end
      end
      S_SCL_LOW: begin
        if (quarter) begin
          next_sda_drv = drive_low(bitc, tx, sh[7], ctrl.ack_enable);
        end
        if (tmr_done) begin
          if (bitc == BIT_END) begin
            set_flag   = 1'b1;
            next_state = S_WAIT;
          end else begin
            next_scl_drv = 1'b0;
            next_tmr     = HALF;
            next_state   = S_SCL_HIGH;
          end
        end
      end
      S_SCL_HIGH: begin
        if (!scl_s) begin
          next_tmr = HALF; // Slave stretches the clock
        end else if (tmr_done) begin
          next_sh = {sh[6:0], sda_s};
          if ((bitc < BIT_ACK && tx && sh[7] && !sda_s) ||
              (bitc == BIT_ACK && !tx && !ctrl.ack_enable && !sda_s)) begin
            next_pend    = ST_ARB_LOST;
            next_scl_drv = 1'b0;
            next_sda_drv = 1'b0;
            set_flag     = 1'b1;
            next_state   = S_LOST;
          end else begin
            rx_cap       = (bitc == 4'd7) && !tx;
            next_bitc    = (bitc == BIT_ACK) ? BIT_END : bitc + 4'd1;
            if (bitc == BIT_ACK) begin
              if (addr_ph) begin
                next_pend = rd_mode ? (sda_s ? ST_AR_NACK : ST_AR_ACK)
                                    : (sda_s ? ST_AW_NACK : ST_AW_ACK);
              end else if (tx) begin
                next_pend = sda_s ? ST_TX_NACK : ST_TX_ACK;
              end else begin
                next_pend = ctrl.ack_enable ? ST_RX_ACK : ST_RX_NACK;
              end
            end
            next_scl_drv = 1'b1;
            next_tmr     = HALF;
            next_state   = S_SCL_LOW;
          end
        end
      end
      S_WAIT: begin
        // SCL held low until software clears the flag
        if (go) begin
          next_tmr = HALF;
          if (wr_c.stop_request) begin
            next_state = S_STOP_LOW;
          end else if (wr_c.start_request) begin
            next_state = S_RS_LOW;
          end else if (status == ST_START || status == ST_RSTART) begin
            next_sh      = data;
            next_rd_mode = data[0];
            next_addr_ph = 1'b1;
            next_bitc    = 4'd0;
            next_state   = S_SCL_LOW;
          end else if (status == ST_AR_ACK || status == ST_RX_ACK) begin
            next_addr_ph = 1'b0;
            next_bitc    = 4'd0;
            next_state   = S_SCL_LOW;
          end else if (is_tx_stat(status)) begin
            next_sh      = data;
            next_addr_ph = 1'b0;
            next_bitc    = 4'd0;
            next_state   = S_SCL_LOW;
          end else begin
            next_pend = status;
            set_flag  = 1'b1;
          end
        end
      end
      S_LOST: begin
        next_scl_drv = 1'b0;
        next_sda_drv = 1'b0;
        if (go) begin
          next_rs    = 1'b0;
          next_state = wr_c.start_request ? S_WAIT_FREE : S_IDLE;
        end
      end
      S_STOP_LOW: begin
        if (quarter) next_sda_drv = 1'b1;
        if (tmr_done) begin
          next_scl_drv = 1'b0;
          next_tmr     = HALF;
          next_state   = S_STOP_HIGH;
        end
      end
      S_STOP_HIGH: begin
        if (!scl_s) begin
          next_tmr = HALF;
        end else if (tmr_done) begin
          next_sda_drv = 1'b0;
          clr_stop     = 1'b1;
          next_tmr     = HALF;
          next_state   = S_STOP_END;
        end
      end
      S_STOP_END: begin
        if (tmr_done) begin
          next_rs    = 1'b0;
          next_state = ctrl.start_request ? S_WAIT_FREE : S_IDLE;
        end
      end
      S_RS_LOW: begin
        if (quarter) next_sda_drv = 1'b0;
        if (tmr_done) begin
          next_scl_drv = 1'b0;
          next_tmr     = HALF;
          next_state   = S_RS_HIGH;
        end
      end
      S_RS_HIGH: begin
        if (!scl_s) begin
          next_tmr = HALF;
        end else if (tmr_done) begin
          next_sda_drv = 1'b1;
          next_tmr     = HALF;
          next_state   = S_START_HOLD;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  // Engine registers; disabling the interface drops back to idle
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state   <= S_IDLE;
      tmr     <= 8'h00;
      bitc    <= 4'd0;
      sh      <= 8'h00;
      pend    <= STAT_RESET;
      rd_mode <= 1'b0;
      addr_ph <= 1'b0;
      rs      <= 1'b0;
      scl_drv <= 1'b0;
      sda_drv <= 1'b0;
    end else if (!ctrl.iface_enable && !go) begin
      // A go write that also turns the interface on must not be lost
      state   <= S_IDLE;
      scl_drv <= 1'b0;
      sda_drv <= 1'b0;
      rs      <= 1'b0;
    end else begin
      state   <= next_state;
      tmr     <= next_tmr;
      bitc    <= next_bitc;
      sh      <= next_sh;
      pend    <= next_pend;
      rd_mode <= next_rd_mode;
      addr_ph <= next_addr_ph;
      rs      <= next_rs;
      scl_drv <= next_scl_drv;
      sda_drv <= next_sda_drv;
    end
  end

  // --------------------------------------------------------------------
  // Software registers
  // --------------------------------------------------------------------
  // Control: hardware set of the flag wins over a clear in the same cycle
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl <= twm_ctrl_t'(CTRL_RESET);
    end else begin
      if (wr_ctrl) begin
        ctrl.ack_enable    <= wr_c.ack_enable;
        ctrl.start_request <= wr_c.start_request;
        ctrl.iface_enable  <= wr_c.iface_enable;
        ctrl.irq_enable    <= wr_c.irq_enable;
      end
      if (wr_ctrl) begin
        ctrl.stop_request <= wr_c.stop_request;
      end else if (clr_stop) begin
        ctrl.stop_request <= 1'b0;
      end
      if (set_flag && ctrl.iface_enable) begin
        ctrl.flag <= 1'b1;
      end else if (wr_ctrl && wr_c.flag) begin
        ctrl.flag <= 1'b0;
      end
      if (wr_data && !ctrl.flag) begin
        ctrl.write_collision <= 1'b1;
      end else if (wr_data) begin
        ctrl.write_collision <= 1'b0;
      end
      ctrl.rsvd <= 1'b0;
    end
  end

  // Status follows each flag rise; data loads from software or the bus
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      status <= STAT_RESET;
      data   <= DATA_RESET;
    end else begin
      if (set_flag && ctrl.iface_enable) status <= next_pend;
      if (rx_cap && ctrl.iface_enable) begin
        data <= {sh[6:0], sda_s};
      end else if (wr_data && ctrl.flag) begin
        data <= WDATA;
      end
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  // All outputs registered; pins are open drain so the level is always 0
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RDATA   <= 8'h00;
      SCL_OUT <= 1'b0;
      SDA_OUT <= 1'b0;
      SCL_OE  <= 1'b0;
      SDA_OE  <= 1'b0;
      IRQ     <= 1'b0;
    end else begin
      RDATA   <= RD ? rd_mux : 8'h00;
      SCL_OUT <= 1'b0;
      SDA_OUT <= 1'b0;
      SCL_OE  <= scl_drv;
      SDA_OE  <= sda_drv;
      IRQ     <= ctrl.flag && ctrl.irq_enable;
    end
  end

endmodule : twm_master_rx
`default_nettype wire

//--- common/twm_pkg.sv
`default_nettype none

package twm_pkg;

  // --------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------
  localparam int unsigned REG_AW   = 2;
  localparam logic [1:0]  OFF_CTRL = 2'h0;
  localparam logic [1:0]  OFF_STAT = 2'h1;
  localparam logic [1:0]  OFF_DATA = 2'h2;

  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] STAT_RESET = 8'hf8;
  localparam logic [7:0] DATA_RESET = 8'hff;

  // Status field sits above three prescaler bits that read as zero
  localparam int unsigned STAT_LSB      = 3;
  localparam logic [2:0]  PRESCALE_ZERO = 3'h0;

  // --------------------------------------------------------------------
  // Status codes
  // --------------------------------------------------------------------
  localparam logic [7:0] ST_START    = 8'h08;
  localparam logic [7:0] ST_RSTART   = 8'h10;
  localparam logic [7:0] ST_AW_ACK   = 8'h18;
  localparam logic [7:0] ST_AW_NACK  = 8'h20;
  localparam logic [7:0] ST_TX_ACK   = 8'h28;
  localparam logic [7:0] ST_TX_NACK  = 8'h30;
  localparam logic [7:0] ST_ARB_LOST = 8'h38;
  localparam logic [7:0] ST_AR_ACK   = 8'h40;
  localparam logic [7:0] ST_AR_NACK  = 8'h48;
  localparam logic [7:0] ST_RX_ACK   = 8'h50;
  localparam logic [7:0] ST_RX_NACK  = 8'h58;

  // --------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------
  localparam int unsigned CLK_NS      = 50;
  localparam int unsigned SCL_HALF_NS = 5000;
  localparam int unsigned BUS_FREE_NS = 4700;
  localparam int unsigned HALF_CYC    = (SCL_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned FREE_CYC    = (BUS_FREE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SYNC_LEN    = 3;
  localparam logic [3:0]  BIT_ACK     = 4'd8;
  localparam logic [3:0]  BIT_END     = 4'd9;

  // --------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------
  typedef struct packed {
    logic flag;
    logic ack_enable;
    logic start_request;
    logic stop_request;
    logic write_collision;
    logic iface_enable;
    logic rsvd;
    logic irq_enable;
  } twm_ctrl_t;

  typedef enum logic [3:0] {
    S_IDLE, S_WAIT_FREE, S_START_HOLD, S_SCL_LOW, S_SCL_HIGH, S_WAIT,
    S_LOST, S_STOP_LOW, S_STOP_HIGH, S_STOP_END, S_RS_LOW, S_RS_HIGH
  } twm_state_t;

endpackage : twm_pkg
`default_nettype wire

//--- sim/twm_master_rx_properties.sv
`timescale 1ns/1ps
`default_nettype none

module twm_master_rx_properties
  import twm_pkg::*;
#(
  parameter int unsigned HALF_CYCLES = twm_pkg::HALF_CYC
) (
  // Clock and reset
  input wire logic                       MCLK,
  input wire logic                       RESET_N,
  // Register port
  input wire logic [twm_pkg::REG_AW-1:0] ADDR,
  input wire logic [7:0]                 WDATA,
  input wire logic                       WR,
  input wire logic                       RD,
  input wire logic [7:0]                 RDATA,
  // Two-wire bus
  input wire logic                       SCL_IN,
  input wire logic                       SCL_OUT,
  input wire logic                       SCL_OE,
  input wire logic                       SDA_IN,
  input wire logic                       SDA_OUT,
  input wire logic                       SDA_OE,
  input wire logic                       IRQ
);
  // Cycles SCL held low; saturates so a long wait cannot wrap
  logic [7:0] low_cnt;
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      low_cnt <= 8'h00;
    end else begin
      low_cnt <= !SCL_OE ? 8'h00 : (low_cnt == 8'hff ? low_cnt : low_cnt + 8'h01);
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  a_rdata_idle: assert property (!RD |=> RDATA == 8'h00)
    else $error("read data not zero outside answer cycle");
  a_status_low_zero: assert property (RD && ADDR == OFF_STAT |=> RDATA[2:0] == PRESCALE_ZERO)
    else $error("status low bits not zero");
  a_unmapped_zero: assert property (RD && ADDR == 2'h3 |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_open_drain: assert property (SCL_OUT == 1'b0 && SDA_OUT == 1'b0)
    else $error("bus output level not zero");
  a_start_free: assert property ($rose(SDA_OE) && !SCL_OE |-> $past(SDA_IN) && SCL_IN)
    else $error("start issued on a busy bus");
  a_stop_order: assert property ($fell(SDA_OE) && !SCL_OE |-> !$past(SCL_OE, 2))
    else $error("data line released without clock setup");
  a_disable_release: assert property (WR && ADDR == OFF_CTRL && !WDATA[2]
    |-> ##[1:3] !SCL_OE && !SDA_OE)
    else $error("lines driven while disabled");
  a_irq_masked: assert property (WR && ADDR == OFF_CTRL && !WDATA[0] |-> ##2 !IRQ)
    else $error("interrupt request while masked");
  a_scl_low_half: assert property ($fell(SCL_OE) |-> low_cnt >= HALF_CYCLES)
    else $error("clock low phase too short");
endmodule : twm_master_rx_properties

bind twm_master_rx twm_master_rx_properties #(.HALF_CYCLES(HALF_CYCLES)) u_props (
  .MCLK(MCLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .SCL_IN(SCL_IN), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE), .SDA_IN(SDA_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .IRQ(IRQ));

`default_nettype wire

//--- sim/twm_slave_model.sv
`timescale 1ns/1ps
`default_nettype none

module twm_slave_model #(
  parameter logic [6:0] ADDR7 = 7'h52
) (
  // Bus wires
  input  wire logic       scl,
  input  wire logic       sda,
  // Byte offered for the next read
  input  wire logic [7:0] tx_data,
  output logic            sda_low
);
  logic       active = 1'b0;
  logic       in_addr = 1'b0;
  logic       rd = 1'b0;
  logic       sending = 1'b0;
  logic       ack_drv = 1'b0;
  logic [3:0] cnt = 4'h0;
  logic [7:0] sh = 8'h00;

  // Start restarts the frame, stop leaves it; the clock fall that
  // follows a start wraps the count to bit zero
  always @(negedge sda) if (scl === 1'b1) begin
    active = 1'b1; in_addr = 1'b1; cnt = 4'hf; sending = 1'b0; ack_drv = 1'b0;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    active = 1'b0; sending = 1'b0; ack_drv = 1'b0;
  end
  // Sample on clock rise; master NACK ends sending
  always @(posedge scl) if (active) begin
    if (cnt < 4'd8) sh = {sh[6:0], sda};
    else if (sending) sending = !sda;
  end
  // Advance on clock fall, so data only moves while the clock is low
  always @(negedge scl) if (active) begin
    cnt = (cnt == 4'd8) ? 4'd0 : cnt + 4'd1;
    ack_drv = 1'b0;
    if (cnt == 4'd8 && in_addr) begin
      rd = sh[0];
      ack_drv = (sh[7:1] == ADDR7);
      sending = ack_drv && rd;
      in_addr = 1'b0;
    end else if (cnt == 4'd8) ack_drv = !rd;
  end
  // Live byte: bench changes it only while the master waits
  assign sda_low = active && (ack_drv || (sending && cnt < 4'd8 && !tx_data[3'd7 - cnt[2:0]]));
endmodule : twm_slave_model

`default_nettype wire

//--- sim/twm_master_rx_bench.sv
`timescale 1ns/1ps
`default_nettype none

module twm_master_rx_bench;
  import twm_pkg::*;
  localparam logic [6:0] SLV = 7'h52;
  logic       MCLK = 1'b0;
  logic       RESET_N = 1'b0;
  logic [1:0] ADDR = 2'h0;
  logic [7:0] WDATA = 8'h00;
  logic       WR = 1'b0;
  logic       RD = 1'b0;
  logic [7:0] RDATA;
  logic       SCL_OUT, SCL_OE, SDA_OUT, SDA_OE, IRQ, sda_low;
  logic       arb_pull = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic [7:0] b;
  logic       rd_d = 1'b0;
  logic [15:0] notes[$];
  int         bad_count = 0;
  int         cmp_count = 0;
  int         seed = 32'hfcdc;
  // Wired-AND bus with pull-ups
  wire scl_w = !SCL_OE;
  wire sda_w = !(SDA_OE || sda_low || arb_pull);

  twm_master_rx #(.HALF_CYCLES(8), .FREE_CYCLES(4)) DUT (
    .MCLK(MCLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .SCL_IN(scl_w), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE), .SDA_IN(sda_w),
    .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .IRQ(IRQ));
  twm_slave_model #(.ADDR7(SLV)) slave (.scl(scl_w), .sda(sda_w), .tx_data(tx_data),
    .sda_low(sda_low));

  // Clock
  initial forever #25 MCLK = ~MCLK;

  task automatic fail(input string m);
    bad_count++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask : fail
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] msk);
    cmp_count++;
    if ((got & msk) !== (exp & msk)) fail($sformatf("read %h want %h", got, exp));
  endtask : cmp8
  task automatic cmp_bit(input logic got, input logic exp, input string m);
    cmp_count++;
    if (got !== exp) fail(m);
  endtask : cmp_bit
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge MCLK); WR <= 1'b1; ADDR <= a; WDATA <= d;
    @(posedge MCLK); WR <= 1'b0;
  endtask : wr
  // Every read leaves a note; a zero mask marks a poll
  task automatic rd(input logic [1:0] a, input logic [7:0] e, input logic [7:0] m,
                    output logic [7:0] d);
    notes.push_back({m, e});
    @(posedge MCLK); RD <= 1'b1; ADDR <= a;
    @(posedge MCLK); RD <= 1'b0;
    @(posedge MCLK); d = RDATA;
  endtask : rd
  task automatic chk(input logic [1:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    logic [7:0] d;
    rd(a, e, m, d);
  endtask : chk
  // Bounded poll of the flag
  task automatic wait_flag;
    logic [7:0] d;
    for (int i = 0; i < 300; i++) begin
      rd(OFF_CTRL, 8'h00, 8'h00, d);
      if (d[7] === 1'b1) return;
    end
    fail("flag timeout");
  endtask : wait_flag
  task automatic go(input logic [7:0] c);
    wr(OFF_CTRL, c);
    wait_flag;
  endtask : go
  task automatic end_sim;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim

  // Result watcher: answer stands the cycle after the strobe
  always @(posedge MCLK) begin : watch
    logic [15:0] n;
    rd_d <= RD;
    if (rd_d && notes.size() > 0) begin
      n = notes.pop_front();
      if (n[15:8] != 8'h00) cmp8(RDATA, n[7:0], n[15:8]);
    end
  end

  // Watchdog, well past the expected run
  initial begin
    #2000000;
    fail("watchdog");
    end_sim;
  end

  // Main sequence
  initial begin
    repeat (8) @(posedge MCLK);
    RESET_N <= 1'b1;
    chk(OFF_CTRL, CTRL_RESET);
    chk(OFF_STAT, STAT_RESET);
    chk(OFF_DATA, DATA_RESET);
    chk(2'h3, 8'h00);
    wr(OFF_STAT, 8'h00);
    chk(OFF_STAT, STAT_RESET);
    wr(OFF_DATA, 8'h12);
    chk(OFF_CTRL, 8'h08);
    chk(OFF_DATA, DATA_RESET);
    wr(OFF_CTRL, 8'ha0);
    repeat (60) @(posedge MCLK);
    chk(OFF_CTRL, 8'h00, 8'h80);
    cmp_bit(SDA_OE, 1'b0, "start while disabled");
    $display("test registers done");
    go(8'ha5);
    chk(OFF_STAT, ST_START);
    cmp_bit(IRQ, 1'b1, "no interrupt request");
    wr(OFF_DATA, {SLV, 1'b1});
    chk(OFF_CTRL, 8'h00, 8'h08);
    go(8'hc5);
    chk(OFF_STAT, ST_AR_ACK);
    for (int i = 0; i < 3; i++) begin
      b = 8'($random(seed));
      tx_data <= b;
      go(i < 2 ? 8'hc5 : 8'h85);
      chk(OFF_STAT, i < 2 ? ST_RX_ACK : ST_RX_NACK);
      chk(OFF_DATA, b);
    end
    go(8'h85);
    chk(OFF_STAT, ST_RX_NACK);
    $display("test receive done");
    go(8'ha5);
    chk(OFF_STAT, ST_RSTART);
    wr(OFF_DATA, {SLV, 1'b0});
    go(8'h85);
    chk(OFF_STAT, ST_AW_ACK);
    go(8'ha5);
    wr(OFF_DATA, {7'h2d, 1'b1});
    go(8'h85);
    chk(OFF_STAT, ST_AR_NACK);
    go(8'h85);
    chk(OFF_STAT, ST_AR_NACK);
    go(8'hb5);
    chk(OFF_STAT, ST_START);
    chk(OFF_CTRL, 8'h00, 8'h10);
    $display("test restart done");
    wr(OFF_DATA, 8'hff);
    wr(OFF_CTRL, 8'h85);
    @(negedge scl_w);
    @(posedge MCLK);
    arb_pull <= 1'b1;
    wait_flag;
    arb_pull <= 1'b0;
    chk(OFF_STAT, ST_ARB_LOST);
    wr(OFF_CTRL, 8'h84);
    repeat (60) @(posedge MCLK);
    chk(OFF_CTRL, 8'h00, 8'h80);
    cmp_bit(SCL_OE || SDA_OE, 1'b0, "bus kept after loss");
    go(8'ha5);
    chk(OFF_STAT, ST_START);
    $display("test arbitration done");
    wr(OFF_DATA, {SLV, 1'b1});
    go(8'hc5);
    b = 8'($random(seed));
    tx_data <= b;
    go(8'h85);
    chk(OFF_DATA, b);
    wr(OFF_CTRL, 8'h95);
    repeat (100) @(posedge MCLK);
    cmp_bit(scl_w && sda_w, 1'b1, "bus not released");
    chk(OFF_CTRL, 8'h00, 8'h90);
    $display("test stop done");
    end_sim;
  end
endmodule : twm_master_rx_bench

`default_nettype wire
